// ===== shared/dma_chan_regs.svh
// register offsets, field positions and reset values of the dma channel block
`ifndef DMA_CHAN_REGS_SVH
`define DMA_CHAN_REGS_SVH

`define NUM_CH        16
`define NUM_EXT       4

// byte addresses on the register port
`define PIN_SEL_OFS   8'h40
`define PEND_OFS      8'h44
`define IMASK_OFS     8'h48
`define EMASK_OFS     8'h4C

// channel_config_reg fields
`define F_ACTIVATE    0
`define F_BUS_SEL     1
`define F_INT_REQ     2
`define F_FLYBY       3
`define F_REQUESTOR   7:4
`define F_PRIORITY    11:8
`define F_IGNORE      14:12
`define F_SENSE       15
`define F_POLARITY    16
`define F_EARLY_ACK   17
`define F_TYPE        20:18
`define F_COUNT       31:24

// requestor numbers above the four external lines
`define RQ_HOST       4'h4
`define RQ_FILTER     4'h5

// reset values and writable bits
`define CFG_RST       32'h0000_0000
`define PIN_SEL_RST   8'h00
`define PIN_SEL_MASK  8'h03
`define MASK_RST      16'h0000

`endif

// ===== shared/dma_chan_pkg.sv
// types shared by the dma channel block
package dma_chan_pkg;

   typedef enum logic [2:0] {
      MEM_TO_FIFO,
      FIFO_TO_MEM,
      PER_TO_FIFO,
      FIFO_TO_PER,
      MEM_TO_PER_FLY,
      PER_TO_MEM_FLY,
      TYPE_RSVD6,
      TYPE_RSVD7
   } xfer_type_t;

   typedef logic [2:0] ign_cnt_t;

endpackage

// ===== verilog/ext_request_cond.sv
// conditioning of one external request line: sense, polarity and ignore window
`timescale 1ns/1ps
`default_nettype none

module ext_request_cond
   import dma_chan_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire logic     rstn,
   input  wire logic     ce,
   input  wire logic     req_pin,
   input  wire logic     sense_edge,
   input  wire logic     pol_high,
   input  wire ign_cnt_t ignore_cycles,
   input  wire logic     consume,
   input  wire logic     early_ack,
   output logic          held,
   output logic          fresh,
   output logic          sampled
);

   logic     prev_reg;
   logic     prev_next;
   logic     held_reg;
   logic     held_next;
   ign_cnt_t cnt_reg;
   ign_cnt_t cnt_next;
   logic     level_on;

   always_comb
   begin
      level_on = (req_pin == pol_high);
      if (sense_edge)
         fresh = level_on && !prev_reg;
      else
         fresh = level_on && cnt_reg == 3'h0;
      sampled = fresh && !held_reg;
      held = held_reg;
      prev_next = level_on;
      // the grant that consumes also retires the request seen this cycle;
      // a level request latches only for the early acknowledge, so an unbound line leaves nothing stale
      held_next = consume ? 1'b0 : (held_reg || (fresh && sense_edge) || early_ack);
      if (consume || early_ack)
         cnt_next = ignore_cycles;
      else if (cnt_reg != 3'h0)
         cnt_next = cnt_reg - 3'h1;
      else
         cnt_next = cnt_reg;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         prev_reg <= 1'b0;
         held_reg <= 1'b0;
         cnt_reg <= 3'h0;
      end
      else if (ce)
      begin
         prev_reg <= prev_next;
         held_reg <= held_next;
         cnt_reg <= cnt_next;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   chk_ignore_window: assert property (
      ce && (consume || early_ack) && ignore_cycles != 3'h0 && !sense_edge |=> sense_edge || !fresh)
      else $error("level request seen inside ignore window");
   chk_edge_sense: assert property (
      ce && $past(ce) && $past(rstn) && sense_edge && fresh && $stable(pol_high) |-> $past(req_pin) != pol_high)
      else $error("edge request without a preceding inactive level");
   chk_level_pol: assert property (
      req_pin != pol_high |-> !fresh)
      else $error("request taken at the inactive level");

endmodule

`default_nettype wire

// ===== verilog/dma_channel_request_config.sv
// channel configuration, request handling, arbitration and status of the dma block
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_regs.svh"

module dma_channel_request_config
   import dma_chan_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   input  wire logic [3:0]  dma_request_line,
   input  wire logic        host_port_req,
   input  wire logic        filter_coprocessor_req,
   input  wire logic [1:0]  done_i,
   output logic [1:0]       done_o,
   output logic [1:0]       done_oe,
   output logic [3:0]       transfer_ack_line,
   output logic [1:0]       early_request_ack,
   output logic             grant_valid,
   output logic [3:0]       grant_channel,
   output logic             grant_bus,
   output xfer_type_t       grant_type,
   output logic             irq_pic,
   output logic             irq_host
);

   logic [31:0] cfg_reg [`NUM_CH];
   logic [31:0] cfg_next [`NUM_CH];
   logic [7:0]  pin_sel_reg, pin_sel_next;
   logic [15:0] pend_reg, pend_next;
   logic [15:0] imask_reg, imask_next;
   logic [15:0] emask_reg, emask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        gvalid_reg, gvalid_next;
   logic [3:0]  gch_reg, gch_next;
   logic        gbus_reg, gbus_next;
   xfer_type_t  gtype_reg, gtype_next;
   logic [3:0]  tack_reg, tack_next;
   logic [1:0]  eack_reg, eack_next;
   logic [1:0]  done_o_reg, done_o_next;
   logic        irq_pic_reg, irq_pic_next;
   logic        irq_host_reg, irq_host_next;

   logic [3:0]  line_sense, line_pol, line_eack_en;
   logic [3:0]  held, fresh, sampled, eack_fire;
   ign_cnt_t    line_ign [`NUM_EXT];
   logic [15:0] elig, pend_set;
   logic        found, complete;
   logic [3:0]  best_c, best_p, rq, brq, reg_idx;
   xfer_type_t  ty, best_ty;
   logic        intr, fly, preq, req, par_ok;
   logic [7:0]  cnt;
   logic [1:0]  done_mode;
   logic        higher_waiting;

   for (genvar r = 0; r < `NUM_EXT; r++)
   begin : g_line
      ext_request_cond u_cond (
         .clk_sys       (clk_sys),
         .rstn          (rstn),
         .ce            (ce),
         .req_pin       (dma_request_line[r]),
         .sense_edge    (line_sense[r]),
         .pol_high      (line_pol[r]),
         .ignore_cycles (line_ign[r]),
         .consume       (tack_next[r]),
         .early_ack     (eack_fire[r]),
         .held          (held[r]),
         .fresh         (fresh[r]),
         .sampled       (sampled[r])
      );
   end

   always_comb
   begin
      done_mode = ~pin_sel_reg[1:0];
      // a line takes its settings from the active external channel bound to it
      for (int r = 0; r < `NUM_EXT; r++)
      begin
         line_sense[r] = 1'b0;
         line_pol[r] = 1'b1;
         line_ign[r] = 3'h0;
         line_eack_en[r] = 1'b0;
         for (int c = 0; c < `NUM_CH; c++)
            if (cfg_reg[c][`F_ACTIVATE] && !cfg_reg[c][`F_INT_REQ] && cfg_reg[c][`F_REQUESTOR] == 4'(r))
            begin
               line_sense[r] = cfg_reg[c][`F_SENSE];
               line_pol[r] = cfg_reg[c][`F_POLARITY];
               line_ign[r] = cfg_reg[c][`F_IGNORE];
               // only requestors 1 and 2 own an acknowledge pin
               line_eack_en[r] = cfg_reg[c][`F_EARLY_ACK] && ((r == 1 && !done_mode[0]) || (r == 2 && !done_mode[1]));
            end
         eack_fire[r] = sampled[r] && line_eack_en[r];
      end

      found = 1'b0;
      best_c = 4'h0;
      best_p = 4'h0;
      for (int c = 0; c < `NUM_CH; c++)
      begin
         ty = xfer_type_t'(cfg_reg[c][`F_TYPE]);
         rq = cfg_reg[c][`F_REQUESTOR];
         intr = cfg_reg[c][`F_INT_REQ];
         fly = cfg_reg[c][`F_FLYBY] || ty == MEM_TO_PER_FLY || ty == PER_TO_MEM_FLY;
         if (rq < 4'h4)
            preq = line_eack_en[rq[1:0]] ? held[rq[1:0]] : (held[rq[1:0]] || fresh[rq[1:0]]);
         else if (rq == `RQ_HOST)
            preq = host_port_req;
         else
            preq = (rq == `RQ_FILTER) && filter_coprocessor_req;
         case (ty)
            MEM_TO_FIFO, FIFO_TO_MEM: req = intr;
            PER_TO_FIFO: req = intr || preq;
            FIFO_TO_PER: req = intr || preq;
            MEM_TO_PER_FLY: req = preq;
            PER_TO_MEM_FLY: req = preq;
            default: req = 1'b0;
         endcase
         if (fly && intr)
            req = 1'b0;
         if (ty == MEM_TO_FIFO || ty == PER_TO_FIFO)
            par_ok = (c % 2) == 0;
         else if (ty == FIFO_TO_MEM || ty == FIFO_TO_PER)
            par_ok = (c % 2) == 1;
         else
            par_ok = 1'b1;
         elig[c] = cfg_reg[c][`F_ACTIVATE] && req && par_ok;
         // ties go to the lowest channel number
         if (elig[c] && (!found || cfg_reg[c][`F_PRIORITY] > best_p))
         begin
            found = 1'b1;
            best_c = 4'(c);
            best_p = cfg_reg[c][`F_PRIORITY];
         end
      end

      best_ty = xfer_type_t'(cfg_reg[best_c][`F_TYPE]);
      brq = cfg_reg[best_c][`F_REQUESTOR];
      cnt = cfg_reg[best_c][`F_COUNT];
      complete = found && cnt <= 8'h01;
      cfg_next = cfg_reg;
      pend_set = 16'h0000;
      tack_next = 4'h0;
      done_o_next = 2'h0;
      gvalid_next = found;
      gch_next = best_c;
      gbus_next = cfg_reg[best_c][`F_BUS_SEL];
      gtype_next = best_ty;
      if (found)
      begin
         if (!cfg_reg[best_c][`F_INT_REQ] && brq < 4'h4)
            tack_next[brq[1:0]] = 1'b1;
         cfg_next[best_c][`F_COUNT] = complete ? 8'h00 : cnt - 8'h01;
         if (complete)
         begin
            cfg_next[best_c][`F_ACTIVATE] = 1'b0;
            pend_set[best_c] = 1'b1;
            if (!cfg_reg[best_c][`F_INT_REQ] && (brq == 4'h1 || brq == 4'h2) && done_mode[brq[1]])
               done_o_next[brq[1]] = 1'b1;
         end
      end

      // done from the peripheral ends every channel bound to its line
      for (int c = 0; c < `NUM_CH; c++)
         for (int k = 0; k < 2; k++)
            if (done_i[k] && done_mode[k] && !done_o_reg[k] && cfg_reg[c][`F_ACTIVATE] && !cfg_reg[c][`F_INT_REQ]
                && cfg_reg[c][`F_REQUESTOR] == 4'(k + 1))
            begin
               cfg_next[c][`F_ACTIVATE] = 1'b0;
               pend_set[c] = 1'b1;
            end

      reg_idx = reg_addr[5:2];
      pin_sel_next = pin_sel_reg;
      imask_next = imask_reg;
      emask_next = emask_reg;
      pend_next = pend_reg | pend_set;
      if (reg_wr && reg_addr[1:0] == 2'b00)
      begin
         // a software write overrides the hardware update of the same channel
         if (reg_addr[7:6] == 2'b00)
            cfg_next[reg_idx] = reg_wdata;
         else if (reg_addr == `PIN_SEL_OFS)
            pin_sel_next = reg_wdata[7:0] & `PIN_SEL_MASK;
         else if (reg_addr == `PEND_OFS)
            pend_next = (pend_reg & ~reg_wdata[15:0]) | pend_set;
         else if (reg_addr == `IMASK_OFS)
            imask_next = reg_wdata[15:0];
         else if (reg_addr == `EMASK_OFS)
            emask_next = reg_wdata[15:0];
      end

      rdata_next = 32'h0000_0000;
      if (reg_rd && reg_addr[1:0] == 2'b00)
      begin
         if (reg_addr[7:6] == 2'b00)
            rdata_next = cfg_reg[reg_idx];
         else if (reg_addr == `PIN_SEL_OFS)
            rdata_next = {24'h00_0000, pin_sel_reg};
         else if (reg_addr == `PEND_OFS)
            rdata_next = {16'h0000, pend_reg};
         else if (reg_addr == `IMASK_OFS)
            rdata_next = {16'h0000, imask_reg};
         else if (reg_addr == `EMASK_OFS)
            rdata_next = {16'h0000, emask_reg};
      end

      eack_next = eack_fire[2:1];
      irq_pic_next = |(pend_reg & imask_reg);
      irq_host_next = |(pend_reg & emask_reg);
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int c = 0; c < `NUM_CH; c++)
            cfg_reg[c] <= `CFG_RST;
         pin_sel_reg <= `PIN_SEL_RST;
         pend_reg <= 16'h0000;
         imask_reg <= `MASK_RST;
         emask_reg <= `MASK_RST;
         rdata_reg <= 32'h0000_0000;
         gvalid_reg <= 1'b0;
         gch_reg <= 4'h0;
         gbus_reg <= 1'b0;
         gtype_reg <= MEM_TO_FIFO;
         tack_reg <= 4'h0;
         eack_reg <= 2'h0;
         done_o_reg <= 2'h0;
         irq_pic_reg <= 1'b0;
         irq_host_reg <= 1'b0;
      end
      else if (ce)
      begin
         cfg_reg <= cfg_next;
         pin_sel_reg <= pin_sel_next;
         pend_reg <= pend_next;
         imask_reg <= imask_next;
         emask_reg <= emask_next;
         rdata_reg <= rdata_next;
         gvalid_reg <= gvalid_next;
         gch_reg <= gch_next;
         gbus_reg <= gbus_next;
         gtype_reg <= gtype_next;
         tack_reg <= tack_next;
         eack_reg <= eack_next;
         done_o_reg <= done_o_next;
         irq_pic_reg <= irq_pic_next;
         irq_host_reg <= irq_host_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign done_o = done_o_reg;
   assign done_oe = done_o_reg;
   assign transfer_ack_line = tack_reg;
   assign early_request_ack = eack_reg;
   assign grant_valid = gvalid_reg;
   assign grant_channel = gch_reg;
   assign grant_bus = gbus_reg;
   assign grant_type = gtype_reg;
   assign irq_pic = irq_pic_reg;
   assign irq_host = irq_host_reg;

   always_comb
   begin
      higher_waiting = 1'b0;
      for (int c = 0; c < `NUM_CH; c++)
         if (elig[c] && cfg_reg[c][`F_PRIORITY] > cfg_reg[best_c][`F_PRIORITY])
            higher_waiting = 1'b1;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   chk_mem_internal: assert property (
      ce && found && (best_ty == MEM_TO_FIFO || best_ty == FIFO_TO_MEM) |-> cfg_reg[best_c][`F_INT_REQ])
      else $error("memory fifo channel granted without internal request");
   chk_flyby_external: assert property (
      ce && found && cfg_reg[best_c][`F_FLYBY] |-> !cfg_reg[best_c][`F_INT_REQ])
      else $error("flyby channel started with internal request");
   chk_fifo_pairing: assert property (
      ce && found && (best_ty == MEM_TO_FIFO || best_ty == PER_TO_FIFO) |-> !best_c[0])
      else $error("odd channel filled the fifo");
   chk_top_priority: assert property (
      ce && found |-> !higher_waiting)
      else $error("lower priority channel served first");
   chk_grant_issue: assert property (
      ce && found |=> grant_valid && grant_channel == $past(best_c))
      else $error("grant does not name the chosen channel");
   chk_completion_status: assert property (
      ce && complete && !(reg_wr && reg_addr == {2'b00, best_c, 2'b00})
      |=> pend_reg[$past(best_c)] && !cfg_reg[$past(best_c)][`F_ACTIVATE])
      else $error("completed channel not pending");
   chk_done_pulse: assert property (
      ce && complete && !cfg_reg[best_c][`F_INT_REQ] && brq == 4'h1 && done_mode[0] |=> done_o[0] && done_oe[0])
      else $error("done not driven at completion");
   chk_early_first: assert property (
      ce && found && brq < 4'h4 && !cfg_reg[best_c][`F_INT_REQ] && line_eack_en[brq[1:0]] |-> held[brq[1:0]])
      else $error("external request executed before early acknowledge");
   chk_pic_gate: assert property (
      ce && (pend_reg & imask_reg) == 16'h0000 |=> !irq_pic)
      else $error("masked channel reached peripheral interrupt");
   chk_host_gate: assert property (
      ce && (pend_reg & emask_reg) != 16'h0000 |=> irq_host)
      else $error("unmasked pending channel missing on host interrupt");

   cov_flyby_grant: cover property (grant_valid && grant_type == MEM_TO_PER_FLY);
   cov_early_ack: cover property (early_request_ack != 2'h0);
   cov_done_out: cover property (done_oe != 2'h0);

endmodule

`default_nettype wire

// ===== sim/ext_periph_model.sv
// behavioural external peripheral on the request, acknowledge and done pins
`timescale 1ns/1ps
`default_nettype none
module ext_periph_model
(
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic [3:0] load,
   input  wire logic [7:0] load_beats,
   input  wire logic [3:0] act_low,
   input  wire logic [1:0] term,
   input  wire logic [3:0] transfer_ack_line,
   input  wire logic [1:0] early_request_ack,
   input  wire logic [1:0] done_o,
   input  wire logic [1:0] done_oe,
   output logic [3:0]      dma_request_line,
   output logic [1:0]      done_i,
   output var int          done_cnt,
   output var int          ea_cnt,
   output var int          ea_cyc
);
   logic [7:0] beats_reg [4];
   int         cyc = 0;
   // request stays up until transfer acks use up its loaded beats; an early ack alone never drops it
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      for (int n = 0; n < 4; n++)
      begin
         if (!rstn)
            beats_reg[n] <= 8'h00;
         else if (load[n])
            beats_reg[n] <= load_beats;
         else if (transfer_ack_line[n] && beats_reg[n] != 8'h00)
            beats_reg[n] <= beats_reg[n] - 8'h01;
      end
   end
   always_comb
   begin
      for (int n = 0; n < 4; n++)
      begin
         dma_request_line[n] = (beats_reg[n] != 8'h00) ^ act_low[n];
      end
   end
   // shared pin: the dma block owns it while done_oe is up, else the peripheral drives term
   assign done_i = (done_oe & done_o) | (~done_oe & term);
   // counters cleared under reset so one process alone drives each
   always @(posedge clk_sys)
   begin
      cyc++;
      if (!rstn)
      begin
         done_cnt = 0;
         ea_cnt = 0;
         ea_cyc = 0;
      end
      else
      begin
         if (|(done_o & done_oe))
            done_cnt++;
         if (|early_request_ack)
         begin
            ea_cnt++;
            ea_cyc = cyc;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/dma_channel_request_config_tb.sv
// register-driven testbench of the dma channel request block
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_regs.svh"
module dma_channel_request_config_tb
   import dma_chan_pkg::*;
;
   logic        clk_sys, rstn, ce, reg_wr, reg_rd, host_port_req, filter_coprocessor_req;
   logic [7:0]  reg_addr, load_beats;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [3:0]  dma_request_line, transfer_ack_line, grant_channel, load, act_low;
   logic [1:0]  done_i, done_o, done_oe, early_request_ack, term;
   logic        grant_valid, grant_bus, irq_pic, irq_host, g_bus;
   xfer_type_t  grant_type, g_type;
   int          done_cnt, ea_cnt, ea_cyc, d0, e0, gap;
   int          cyc = 0, g_last = 0, bad_count = 0, tests_run = 0;
   int          gcnt [16];
   int          gq [$];
   logic [3:0]  t_ch [10] = '{2, 4, 6, 1, 3, 5, 8, 10, 12, 13};
   logic [31:0] t_cfg [10] = '{32'h0110_000D, 32'h0300_0005, 32'h0100_0001, 32'h0100_0005, 32'h0204_0005,
                               32'h0118_0005, 32'h0108_0051, 32'h0208_0005, 32'h0110_0049, 32'h0115_0009};
   int          t_n [10] = '{0, 3, 0, 0, 2, 0, 1, 2, 1, 1};
   logic [7:0]  rst_a [7] = '{8'h00, 8'h3C, `PIN_SEL_OFS, `PEND_OFS, `IMASK_OFS, `EMASK_OFS, 8'h50};

   dma_channel_request_config dut_u (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dma_request_line(dma_request_line), .host_port_req(host_port_req),
      .filter_coprocessor_req(filter_coprocessor_req), .done_i(done_i), .done_o(done_o), .done_oe(done_oe),
      .transfer_ack_line(transfer_ack_line), .early_request_ack(early_request_ack), .grant_valid(grant_valid),
      .grant_channel(grant_channel), .grant_bus(grant_bus), .grant_type(grant_type), .irq_pic(irq_pic),
      .irq_host(irq_host));

   ext_periph_model periph_u (.clk_sys(clk_sys), .rstn(rstn), .load(load), .load_beats(load_beats),
      .act_low(act_low), .term(term), .transfer_ack_line(transfer_ack_line),
      .early_request_ack(early_request_ack), .done_o(done_o), .done_oe(done_oe),
      .dma_request_line(dma_request_line), .done_i(done_i), .done_cnt(done_cnt), .ea_cnt(ea_cnt),
      .ea_cyc(ea_cyc));

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // grant log sampled before each edge's updates land
   always @(posedge clk_sys)
   begin
      cyc++;
      if (grant_valid === 1'b1)
      begin
         gcnt[grant_channel]++;
         gq.push_back(int'(grant_channel));
         gap = cyc - g_last;
         g_last = cyc;
         g_type = grant_type;
         g_bus = grant_bus;
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      v = reg_rdata;
   endtask

   task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_num(input string what, input int exp, input int got);
      tests_run++;
      if (got != exp)
      begin
         bad_count++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk_reg($sformatf("register %h", a), exp, v);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic pload(input logic [3:0] m, input logic [7:0] b);
      @(posedge clk_sys);
      load <= m;
      load_beats <= b;
      @(posedge clk_sys);
      load <= 4'h0;
   endtask

   task automatic clr();
      @(negedge clk_sys);
      foreach (gcnt[i])
         gcnt[i] = 0;
      gq.delete();
   endtask

   task automatic test_done();
      $display("counts: %0d checks, %0d mismatches", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      $display("watchdog expired");
      test_done();
   end

   initial
   begin
      {rstn, ce, reg_wr, reg_rd, host_port_req, filter_coprocessor_req} = 6'b010000;
      {reg_addr, reg_wdata, load, load_beats, act_low, term} = '0;
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (rst_a[i])
         rchk(rst_a[i], 32'h0000_0000);
      $display("test reset values done");

      clr();
      wr(8'h00, 32'h0209_2011);
      pload(4'b0010, 8'd2);
      idle(12);
      chk_num("walk grants", 2, gcnt[0]);
      chk_num("ignore gap", 3, gap);
      chk_reg("grant type", 32'h0000_0002, 32'(g_type));
      chk_num("done pulses", 1, done_cnt);
      rchk(`PEND_OFS, 32'h0000_0001);
      rchk(8'h00, 32'h0009_2010);
      $display("test level walk done");

      wr(`IMASK_OFS, 32'h0000_0001);
      idle(2);
      chk_reg("irq pic", 32'h0000_0003, {30'h0, irq_pic, 1'b1});
      chk_reg("irq host", 32'h0000_0000, {31'h0, irq_host});
      wr(`IMASK_OFS, 32'h0000_0000);
      wr(`EMASK_OFS, 32'h0000_0001);
      idle(2);
      chk_reg("irq pair", 32'h0000_0001, {30'h0, irq_pic, irq_host});
      wr(`PEND_OFS, 32'h0000_0001);
      idle(2);
      chk_reg("irq cleared", 32'h0000_0000, {31'h0, irq_host});
      rchk(`EMASK_OFS, 32'h0000_0001);
      wr(`EMASK_OFS, 32'h0000_0000);
      $display("test interrupts done");

      host_port_req <= 1'b1;
      filter_coprocessor_req <= 1'b1;
      pload(4'b0001, 8'd1);
      for (int i = 0; i < 10; i++)
      begin
         clr();
         wr({2'b00, t_ch[i], 2'b00}, t_cfg[i]);
         idle(12);
         chk_num("table grants", t_n[i], gcnt[t_ch[i]]);
         wr({2'b00, t_ch[i], 2'b00}, 32'h0000_0000);
         wr(`PEND_OFS, 32'h0000_FFFF);
      end
      clr();
      wr(8'h1C, 32'h020E_F043);
      idle(12);
      chk_num("host grants", 2, gcnt[7]);
      chk_num("host gap", 1, gap);
      chk_reg("grant bus", 32'h0000_0001, {31'h0, g_bus});
      wr(8'h1C, 32'h0000_0000);
      host_port_req <= 1'b0;
      filter_coprocessor_req <= 1'b0;
      $display("test transfer table done");

      wr(`PIN_SEL_OFS, 32'h0000_00FF);
      rchk(`PIN_SEL_OFS, 32'h0000_0003);
      wr(`PIN_SEL_OFS, 32'h0000_0001);
      @(posedge clk_sys);
      act_low <= 4'b0010;
      wr(8'h00, 32'h010A_8011);
      idle(2);
      clr();
      d0 = done_cnt;
      e0 = ea_cnt;
      pload(4'b0010, 8'd1);
      idle(10);
      chk_num("edge grants", 1, gcnt[0]);
      chk_num("early acks", e0 + 1, ea_cnt);
      chk_num("ack before grant", 1, int'(g_last > ea_cyc));
      chk_num("no done in ack mode", d0, done_cnt);
      wr(8'h00, 32'h0000_0000);
      act_low <= 4'b0000;
      wr(`PEND_OFS, 32'h0000_FFFF);
      $display("test edge and early ack done");

      wr(`PIN_SEL_OFS, 32'h0000_0000);
      wr(8'h00, 32'h0509_0011);
      clr();
      @(posedge clk_sys);
      term <= 2'b01;
      @(posedge clk_sys);
      term <= 2'b00;
      idle(3);
      rd(8'h00, d);
      chk_reg("activate after done", 32'h0000_0000, {31'h0, d[0]});
      rchk(`PEND_OFS, 32'h0000_0001);
      chk_num("no grant on done", 0, gcnt[0]);
      wr(`PEND_OFS, 32'h0000_FFFF);
      $display("test early termination done");

      wr(8'h00, 32'h0109_0201);
      wr(8'h08, 32'h0109_0931);
      clr();
      pload(4'b1001, 8'd1);
      idle(12);
      chk_num("grant count", 2, gq.size());
      if (gq.size() == 2)
      begin
         chk_num("first grant", 2, gq[0]);
         chk_num("second grant", 0, gq[1]);
      end
      $display("test priority done");

      clr();
      wr(8'h10, 32'h0200_0005);
      ce <= 1'b0;
      idle(5);
      chk_num("frozen grants", 0, gcnt[4]);
      ce <= 1'b1;
      idle(4);
      chk_num("thawed grants", 2, gcnt[4]);
      $display("test clock enable done");
      test_done();
   end
endmodule
`default_nettype wire
